// *** hw/rx_port_pkg.sv ***
// Shared constants and carrier types for the GMII / ten-bit receive port
package rx_port_pkg;

  // System clock and management clock timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int MDC_HALF_NS   = 200;
  localparam int MDC_HALF_CYC  = (MDC_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int DIV_W         = 4;
  localparam logic [DIV_W-1:0] MDC_DIV_LAST = DIV_W'(MDC_HALF_CYC - 1);

  // Synchroniser depth for pins and crossings
  localparam int SYNC_STAGES = 2;

  // Bus widths
  localparam int BYTE_W = 8;
  localparam int CODE_W = 10;

  // Management frame layout, first bit sent is bit 63
  localparam int               FRAME_BITS = 64;
  localparam logic [31:0]      PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]       START_BITS = 2'h1;
  localparam logic [1:0]       OP_READ    = 2'h2;
  localparam logic [1:0]       OP_WRITE   = 2'h1;
  localparam logic [1:0]       TA_WRITE   = 2'h2;
  localparam logic [1:0]       TA_READ    = 2'h3;
  localparam logic [15:0]      READ_FILL  = 16'hffff;
  localparam logic [6:0]       TA_POS     = 7'h2e;
  localparam logic [6:0]       DATA_POS   = 7'h30;
  localparam logic [6:0]       LAST_BIT   = 7'h3f;

  typedef logic [CODE_W-1:0] code_group_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              valid;
    logic              error;
  } gmii_rx_t;

  typedef struct packed {
    code_group_t even;
    code_group_t odd;
  } code_pair_t;

  typedef struct packed {
    logic        start;
    logic        read;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
  } mgmt_cmd_t;

  typedef struct packed {
    logic        done;
    logic        busy;
    logic [15:0] rdata;
  } mgmt_rsp_t;

  typedef enum logic [1:0] {
    MG_IDLE,
    MG_SHIFT
  } mgmt_state_t;

endpackage : rx_port_pkg

// *** hw/sync_vec.sv ***
// Multi-flop synchroniser for levels and toggles entering a clock domain
`timescale 1ns/1ps
module sync_vec #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [STAGES-1:0][WIDTH-1:0] stage;
  logic [STAGES-1:0][WIDTH-1:0] next_stage;

  // Only the last stage is visible; earlier ones may be metastable
  always_comb begin
    next_stage = {stage[STAGES-2:0], d_in};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign q_out = stage[STAGES-1];
endmodule : sync_vec

// *** hw/gmii_tbi_receive_port.sv ***
// Receive and sideband port: GMII byte capture, ten-bit pair capture, management
`timescale 1ns/1ps
// Function
// - Ten-bit mode ignores collision; far side holds low
// - GMII byte captured whole on receive clock zero
// - Code-group: data bits, valid bit8, error bit9
// - GMII receive error flags a reception error only while valid is high
// - Odd code-groups on receive clock zero rising
// - Even code-groups on receive clock one rising
// - Stretched clocks never lose or repeat groups
// - GMII mode ignores receive clock one
// - Ten-bit mode reads carrier pin as signal detect
// - GMII mode drives management clock for transfers
// - Ten-bit mode drives shared pin as loopback
// - Ten-bit mode ignores management data line
// - GMII mode runs management reads and writes
module gmii_tbi_receive_port (
  input  wire logic                   clk_sys_in,
  input  wire logic                   resetn_in,
  input  wire logic                   tbi_mode_in,
  input  wire logic                   loopback_enable_in,
  input  wire logic                   receive_clock_zero_in,
  input  wire logic                   receive_clock_one_in,
  input  wire logic [7:0]             rx_data_in,
  input  wire logic                   rx_valid_or_bit8_in,
  input  wire logic                   rx_error_or_bit9_in,
  input  wire logic                   collision_in,
  input  wire logic                   carrier_or_signal_detect_in,
  input  wire logic                   mdio_in,
  input  wire rx_port_pkg::mgmt_cmd_t mgmt_cmd_in,
  output rx_port_pkg::gmii_rx_t       gmii_rx_out,
  output rx_port_pkg::code_pair_t     code_pair_out,
  output logic                        code_pair_valid_out,
  output logic                        collision_out,
  output logic                        carrier_out,
  output logic                        signal_detect_out,
  output logic                        rx_error_pulse_out,
  output rx_port_pkg::mgmt_rsp_t      mgmt_rsp_out,
  output logic                        mgmt_clock_or_loopback_out,
  output logic                        mdio_out,
  output logic                        mdio_oe_out
);
  import rx_port_pkg::*;

  typedef struct packed {
    gmii_rx_t   rx;
    code_pair_t pair;
    logic       pair_valid;
    logic       even_seen;
    logic       err_tog;
  } clk0_state_t;

  typedef struct packed {
    code_group_t even;
    logic        tog;
  } clk1_state_t;

  typedef struct packed {
    mgmt_state_t state;
    logic        busy;
    logic        read;
    logic [63:0] shift;
    logic [6:0]  cnt;
    logic [DIV_W-1:0] div;
    logic        mdc;
    logic        mdio_o;
    logic        oe;
    logic [15:0] rdata;
    logic        done;
    logic        pin;
    logic        col;
    logic        crs;
    logic        sigdet;
    logic        err_seen;
    logic        err_pulse;
  } sys_state_t;

  clk0_state_t s0;
  clk0_state_t next_s0;
  clk1_state_t s1;
  clk1_state_t next_s1;
  sys_state_t  st;
  sys_state_t  next_st;

  logic        rst0_n;
  logic        rst1_n;
  logic        tbi0;
  logic        tbi1;
  logic        col_s;
  logic        crs_s;
  logic        mdio_s;
  logic        err_tog_s;
  code_group_t pins_group;

  function automatic logic [63:0] mgmt_frame(input mgmt_cmd_t c);
    mgmt_frame = {PREAMBLE, START_BITS, c.read ? OP_READ : OP_WRITE, c.phy, c.regad,
                  c.read ? TA_READ : TA_WRITE, c.read ? READ_FILL : c.wdata};
  endfunction : mgmt_frame

  // Code-group bits 9 and 8 come from the error and valid pins
  assign pins_group = {rx_error_or_bit9_in, rx_valid_or_bit8_in, rx_data_in};

  // Reset release and mode level, re-timed into each receive clock
  sync_vec #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_rst0 (
    .clk_in    (receive_clock_zero_in),
    .resetn_in (resetn_in),
    .d_in      (1'b1),
    .q_out     (rst0_n)
  );
  sync_vec #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_rst1 (
    .clk_in    (receive_clock_one_in),
    .resetn_in (resetn_in),
    .d_in      (1'b1),
    .q_out     (rst1_n)
  );
  sync_vec #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_mode0 (
    .clk_in    (receive_clock_zero_in),
    .resetn_in (rst0_n),
    .d_in      (tbi_mode_in),
    .q_out     (tbi0)
  );
  sync_vec #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_mode1 (
    .clk_in    (receive_clock_one_in),
    .resetn_in (rst1_n),
    .d_in      (tbi_mode_in),
    .q_out     (tbi1)
  );
  // Pins and the error toggle into the system clock
  sync_vec #(.WIDTH(4), .STAGES(SYNC_STAGES)) u_sys_sync (
    .clk_in    (clk_sys_in),
    .resetn_in (resetn_in),
    .d_in      ({collision_in, carrier_or_signal_detect_in, mdio_in, s0.err_tog}),
    .q_out     ({col_s, crs_s, mdio_s, err_tog_s})
  );

  // Receive clock one: even code-groups; no edges expected in GMII mode
  always_comb begin
    next_s1 = s1;
    if (tbi1) begin
      next_s1.even = pins_group;
      next_s1.tog  = ~s1.tog;
    end
  end

  always_ff @(posedge receive_clock_one_in or negedge rst1_n) begin
    if (!rst1_n) begin
      s1 <= '0;
    end else begin
      s1 <= next_s1;
    end
  end

  // Receive clock zero: GMII bytes, or odd groups paired with the last even.
  // Both clocks come from one recovery circuit half a period apart, so the
  // even register is read as a half-cycle path, not as a foreign domain.
  always_comb begin
    next_s0 = s0;
    next_s0.pair_valid = 1'b0;
    if (!tbi0) begin
      next_s0.rx.data  = rx_data_in;
      next_s0.rx.valid = rx_valid_or_bit8_in;
      next_s0.rx.error = rx_error_or_bit9_in & rx_valid_or_bit8_in;
      next_s0.even_seen = s1.tog;
      if (rx_error_or_bit9_in && rx_valid_or_bit8_in) begin
        next_s0.err_tog = ~s0.err_tog;
      end
    end else begin
      next_s0.rx = '0;
      // A new even group must have arrived; a stretched edge pairs nothing twice
      if (s1.tog != s0.even_seen) begin
        next_s0.pair.even  = s1.even;
        next_s0.pair.odd   = pins_group;
        next_s0.pair_valid = 1'b1;
        next_s0.even_seen  = s1.tog;
      end
    end
  end

  always_ff @(posedge receive_clock_zero_in or negedge rst0_n) begin
    if (!rst0_n) begin
      s0 <= '0;
    end else begin
      s0 <= next_s0;
    end
  end

  // System clock: sideband pins and the management shifter
  always_comb begin
    next_st = st;
    next_st.done      = 1'b0;
    next_st.col       = col_s & ~tbi_mode_in;
    next_st.crs       = crs_s & ~tbi_mode_in;
    next_st.sigdet    = crs_s & tbi_mode_in;
    next_st.err_seen  = err_tog_s;
    next_st.err_pulse = err_tog_s ^ st.err_seen;
    case (st.state)
      MG_IDLE: begin
        next_st.mdc = 1'b0;
        next_st.oe  = 1'b0;
        next_st.div = '0;
        if (mgmt_cmd_in.start && !tbi_mode_in) begin
          next_st.state  = MG_SHIFT;
          next_st.read   = mgmt_cmd_in.read;
          next_st.shift  = mgmt_frame(mgmt_cmd_in);
          next_st.cnt    = '0;
          next_st.mdio_o = PREAMBLE[31];
          next_st.oe     = 1'b1;
        end
      end
      MG_SHIFT: begin
        next_st.div = st.div + DIV_W'(1);
        if (st.div == MDC_DIV_LAST) begin
          next_st.div = '0;
          next_st.mdc = ~st.mdc;
          if (!st.mdc) begin
            // Rising edge: sample read data while the PHY holds it stable
            if (st.read && st.cnt >= DATA_POS) begin
              next_st.rdata = {st.rdata[14:0], mdio_s};
            end
          end else if (st.cnt == LAST_BIT) begin
            next_st.state = MG_IDLE;
            next_st.oe    = 1'b0;
            next_st.done  = 1'b1;
          end else begin
            // Falling edge: present the next bit, release for read turnaround
            next_st.cnt    = st.cnt + 7'h01;
            next_st.shift  = {st.shift[62:0], 1'b0};
            next_st.mdio_o = st.shift[62];
            next_st.oe     = ~(st.read && (st.cnt + 7'h01) >= TA_POS);
          end
        end
        // Switching to ten-bit mode abandons a transfer in flight
        if (tbi_mode_in) begin
          next_st.state = MG_IDLE;
          next_st.mdc   = 1'b0;
          next_st.oe    = 1'b0;
        end
      end
      default: begin
        next_st.state = MG_IDLE;
      end
    endcase
    next_st.busy = (next_st.state != MG_IDLE);
    next_st.pin  = tbi_mode_in ? loopback_enable_in : next_st.mdc;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign gmii_rx_out                = s0.rx;
  assign code_pair_out              = s0.pair;
  assign code_pair_valid_out        = s0.pair_valid;
  assign collision_out              = st.col;
  assign carrier_out                = st.crs;
  assign signal_detect_out          = st.sigdet;
  assign rx_error_pulse_out         = st.err_pulse;
  assign mgmt_rsp_out               = {st.done, st.busy, st.rdata};
  assign mgmt_clock_or_loopback_out = st.pin;
  assign mdio_out                   = st.mdio_o;
  assign mdio_oe_out                = st.oe;

  a_col_masked: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    tbi_mode_in |=> !collision_out)
    else $error("collision passed in ten-bit mode");

  a_col_sync_delay: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !tbi_mode_in |=> collision_out == $past(collision_in, 3))
    else $error("collision not delayed by synchroniser");

  a_gmii_byte: assert property (
    @(posedge receive_clock_zero_in) disable iff (!rst0_n)
    !tbi0 |=> gmii_rx_out.data == $past(rx_data_in))
    else $error("GMII byte not captured");

  a_gmii_error: assert property (
    @(posedge receive_clock_zero_in) disable iff (!rst0_n)
    (!tbi0 && rx_valid_or_bit8_in && rx_error_or_bit9_in) |=> gmii_rx_out.error)
    else $error("receive error not flagged");

  a_odd_group: assert property (
    @(posedge receive_clock_zero_in) disable iff (!rst0_n)
    code_pair_valid_out |-> code_pair_out.odd == $past(pins_group))
    else $error("odd group wrong");

  a_no_repeat: assert property (
    @(posedge receive_clock_zero_in) disable iff (!rst0_n)
    (tbi0 && s1.tog == s0.even_seen) |=> !code_pair_valid_out)
    else $error("pair repeated without new even group");

  a_even_group: assert property (
    @(posedge receive_clock_one_in) disable iff (!rst1_n)
    tbi1 |=> s1.even == $past(pins_group))
    else $error("even group not captured");

  a_clk1_ignored: assert property (
    @(posedge receive_clock_one_in) disable iff (!rst1_n)
    !tbi1 |=> $stable(s1.even))
    else $error("even register moved in GMII mode");

  a_sigdet: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    tbi_mode_in |=> signal_detect_out == $past(crs_s) && !carrier_out)
    else $error("signal detect wrong");

  a_mdc_half: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in || tbi_mode_in)
    $rose(st.mdc) |-> st.mdc[*8])
    else $error("management clock high too short");

  a_loopback_pin: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    tbi_mode_in |=> mgmt_clock_or_loopback_out == $past(loopback_enable_in))
    else $error("loopback pin wrong");

  a_mdio_quiet: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    tbi_mode_in |=> !mdio_oe_out && !mgmt_rsp_out.busy)
    else $error("management line driven in ten-bit mode");

  a_read_release: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (st.busy && st.read && st.cnt >= TA_POS) |-> !mdio_oe_out)
    else $error("read turnaround driven");

endmodule : gmii_tbi_receive_port

// *** bench/phy_model.sv ***
// Far-side model: receive clocks, receive bus, sideband pins, management responder
`timescale 1ns/1ps
module phy_model #(
  parameter logic [15:0] READ_WORD = 16'h5a3c
) (
  input  wire logic  tbi_in,
  input  wire logic  mdc_in,
  input  wire logic  mdio_dev_in,
  input  wire logic  mdio_oe_in,
  output logic       clk0_out,
  output logic       clk1_out,
  output logic [9:0] bus_out = 10'h000,
  output logic       col_out = 1'b0,
  output logic       crs_out = 1'b0,
  output logic       mdio_line_out,
  output logic [63:0] frame_out = 64'h0
);
  logic ph      = 1'b0;
  int   stretch = 0;
  logic oe_q    = 1'b1;
  int   k       = 0;
  logic last_q  = 1'b0;
  // Half period is 6 plus the stretch set by the last word call; it grows and shrinks
  always begin
    #(6 + stretch) ph = ~ph;
  end
  assign clk0_out = ph;
  assign clk1_out = tbi_in & ~ph; // Antiphase in ten-bit mode, held low otherwise
  always @(posedge mdc_in) begin
    oe_q      <= mdio_oe_in;
    frame_out <= {frame_out[62:0], mdio_line_out};
    // Line is let go once the last data bit has been clocked
    last_q    <= (k == 17);
  end
  always @(negedge mdc_in) begin
    k <= oe_q ? 0 : k + 1;
  end
  // Released line rests on its pull-up; read data goes out on falling clock
  always_comb begin
    if (mdio_oe_in) mdio_line_out = mdio_dev_in;
    else if (!tbi_in && k == 1) mdio_line_out = 1'b0;
    else if (!tbi_in && !last_q && k >= 2 && k <= 17) mdio_line_out = READ_WORD[17 - k];
    else mdio_line_out = 1'b1;
  end
  // Byte or even group now, odd group after the next clock one edge
  task automatic word(input logic [9:0] a, input logic [9:0] b, input int s);
    stretch = s;
    bus_out = a;
    if (tbi_in) begin
      @(posedge clk1_out);
      #1 bus_out = b;
    end
    // Stretch is set once per call, at its start, so it never changes twice in a step
    @(posedge clk0_out);
    #1;
  endtask : word
  // Sideband pins move with no relation to any receive clock
  task automatic side(input logic c, input logic s);
    col_out = c;
    crs_out = s;
  endtask : side
endmodule : phy_model

// *** bench/gmii_tbi_receive_port_tb.sv ***
// Self-checking bench for the GMII / ten-bit receive port
`timescale 1ns/1ps
module gmii_tbi_receive_port_tb;
  import rx_port_pkg::*;
  logic        clk_sys_in  = 1'b0;
  logic        resetn_in   = 1'b0;
  logic        tbi         = 1'b0;
  logic        lb          = 1'b0;
  mgmt_cmd_t   cmd         = '0;
  logic        c0, c1, col, crs, mline, pv, co, ca, sd, ep, mclk, mdo, moe;
  logic [9:0]  bus;
  logic [63:0] frame;
  gmii_rx_t    grx;
  code_pair_t  pair;
  mgmt_rsp_t   rsp;
  int          err_total   = 0;
  int          checks_done = 0;
  int          n_err       = 0;

  always begin
    #12.5 clk_sys_in = ~clk_sys_in;
  end
  // Pulse stands a whole cycle; the falling edge sees it settled
  always @(negedge clk_sys_in) begin
    if (ep === 1'b1) n_err++;
  end

  gmii_tbi_receive_port u_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .tbi_mode_in(tbi),
    .loopback_enable_in(lb), .receive_clock_zero_in(c0), .receive_clock_one_in(c1),
    .rx_data_in(bus[7:0]), .rx_valid_or_bit8_in(bus[8]), .rx_error_or_bit9_in(bus[9]),
    .collision_in(col), .carrier_or_signal_detect_in(crs), .mdio_in(mline),
    .mgmt_cmd_in(cmd), .gmii_rx_out(grx), .code_pair_out(pair), .code_pair_valid_out(pv),
    .collision_out(co), .carrier_out(ca), .signal_detect_out(sd),
    .rx_error_pulse_out(ep), .mgmt_rsp_out(rsp), .mgmt_clock_or_loopback_out(mclk),
    .mdio_out(mdo), .mdio_oe_out(moe));

  phy_model u_phy (
    .tbi_in(tbi), .mdc_in(mclk), .mdio_dev_in(mdo), .mdio_oe_in(moe), .clk0_out(c0),
    .clk1_out(c1), .bus_out(bus), .col_out(col), .crs_out(crs), .mdio_line_out(mline),
    .frame_out(frame));

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  task automatic sys(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : sys

  task automatic t_side;
    sys(1);
    u_phy.side(1'b1, 1'b1);
    sys(2);
    chk_bit("collision early", 1'b0, co);
    sys(1);
    chk_bit("collision", 1'b1, co);
    chk_bit("carrier", 1'b1, ca);
    chk_bit("signal detect gmii", 1'b0, sd);
    u_phy.side(1'b0, 1'b0);
    sys(4);
    chk_bit("collision off", 1'b0, co);
  endtask : t_side

  task automatic t_gmii;
    logic [9:0] w [4] = '{10'h155, 10'h3d5, 10'h1a7, 10'h200};
    int         base;
    sys(20);
    @(posedge c0);
    #1 base = n_err;
    foreach (w[i]) begin
      u_phy.word(w[i], 10'h000, 0);
      chk_vec("gmii rx", {w[i][7:0], w[i][8], w[i][9] & w[i][8]}, grx);
    end
    sys(20);
    chk_vec("error pulses", 64'h1, 64'(n_err - base));
  endtask : t_gmii

  task automatic mgmt(input logic rd, input logic [63:0] exp);
    int n;
    n = 0;
    cmd = '{1'b1, rd, 5'h0b, 5'h13, 16'hc3a5};
    sys(1);
    cmd.start = 1'b0;
    sys(1);
    chk_bit("mgmt busy", 1'b1, rsp.busy);
    while (rsp.done !== 1'b1 && n < 1100) begin
      sys(1);
      n++;
    end
    chk_bit("mgmt done", 1'b1, rsp.done);
    chk_vec("mgmt frame", exp, frame);
    if (rd) chk_vec("read data", 64'h5a3c, rsp.rdata);
  endtask : mgmt

  task automatic t_tbi;
    logic [9:0] g [6] = '{10'h2a5, 10'h15a, 10'h3c3, 10'h03c, 10'h300, 10'h0ff};
    tbi = 1'b1;
    // Far side breaks its tie-low on purpose
    u_phy.side(1'b1, 1'b1);
    sys(20);
    chk_bit("collision ignored", 1'b0, co);
    chk_bit("signal detect", 1'b1, sd);
    chk_bit("carrier in tbi", 1'b0, ca);
    chk_bit("mdio released", 1'b0, moe);
    cmd.start = 1'b1;
    sys(1);
    cmd.start = 1'b0;
    chk_bit("no mgmt in tbi", 1'b0, rsp.busy);
    lb = 1'b1;
    sys(1);
    chk_bit("loopback on", 1'b1, mclk);
    lb = 1'b0;
    sys(1);
    chk_bit("loopback off", 1'b0, mclk);
    @(posedge c0);
    #1;
    for (int i = 0; i < 6; i += 2) begin
      u_phy.word(g[i], g[i+1], (i == 2) ? 5 : 0);
      chk_vec("code pair", {g[i], g[i+1]}, pair);
      chk_bit("pair valid", 1'b1, pv);
    end
    u_phy.side(1'b0, 1'b0);
  endtask : t_tbi

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #200000;
    err_total++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    sys(5);
    t_side();
    t_gmii();
    mgmt(1'b0, {PREAMBLE, START_BITS, OP_WRITE, 5'h0b, 5'h13, TA_WRITE, 16'hc3a5});
    mgmt(1'b1, {PREAMBLE, START_BITS, OP_READ, 5'h0b, 5'h13, 2'h2, 16'h5a3c});
    t_tbi();
    results();
  end
endmodule : gmii_tbi_receive_port_tb
